// ==== verilog/irq_seq_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the interrupt sequencer.
// Assumes: Included by bare name; holds definitions only.
// Notes:   Bit positions refer to the 8-bit control, enable, flag and status registers.
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH

// Interrupt vector loaded into the program counter on entry.
`define IRQ_VECTOR_ADDR      15'h0004

// Control register layout and reset value (edge select comes up rising).
`define CTRL_GIE_BIT         7
`define CTRL_PERIPHERAL_IRQ_ENABLE_BIT        6
`define CTRL_EDGE_BIT        0
`define CTRL_RESET_VAL       8'h01
`define CTRL_IMPL_MASK       8'hC1

// Enable and flag register 0 layout.
`define EN0_EXT_BIT          0
`define EN0_IOC_BIT          4
`define EN0_TMR0_BIT         5
`define EN0_RESET_VAL        8'h00
`define EN0_IMPL_MASK        8'h31
`define FLAG0_RESET_VAL      8'h00

// Status bits that are not part of the saved context.
`define STATUS_TO_BIT        4
`define STATUS_PD_BIT        3

// Timing: the clock runs at quarter-phase rate, four phases per instruction cycle.
`define CLOCK_PERIOD_NS      50
`define INSTR_CYCLE_NS       200
`define PHASES_PER_CYCLE     (`INSTR_CYCLE_NS / `CLOCK_PERIOD_NS)
`define PHASE_Q1             2'h0
`define PHASE_Q4             2'h3

`endif

// ==== verilog/irq_seq_pkg.sv ====
// Purpose: Types shared by the interrupt sequencer files.
// Assumes: Constants live in irq_seq_map.svh.
// Notes:   Entry takes three instruction cycles: flush, save, vector.
package irq_seq_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_FLUSH,
    ST_SAVE,
    ST_VECTOR,
    ST_SLEEP,
    ST_WAKE
  } seq_state_t;

  typedef logic [1:0] phase_t;

endpackage

// ==== verilog/pin_edge_detect.sv ====
// Purpose: Synchronise an asynchronous pin and detect the selected edge.
// Assumes: The pin is held for at least two clocks per level.
// Notes:   The first flop feeds only the second; detection uses stages two and three.
module pin_edge_detect (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic pin_in,
  input  wire logic rising_sel,
  output logic      edge_pulse
);

  logic       sync1_reg;
  logic       sync2_reg;
  logic       last_reg;
  logic       sync1_next;
  logic       sync2_next;
  logic       last_next;
  logic [1:0] fill_reg;
  logic [1:0] fill_next;
  logic       primed;

  // Shift the pin through two synchroniser stages and one history stage.
  // The fill count blocks detection until the history stage holds a real pin sample,
  // so a pin that sits high through reset does not produce a false rising edge.
  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    last_next  = sync2_reg;
    fill_next  = (fill_reg == 2'h3) ? fill_reg : fill_reg + 2'h1;
    primed     = (fill_reg == 2'h3);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      fill_reg  <= 2'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg  <= last_next;
      fill_reg  <= fill_next;
    end
  end

  // Only the selected polarity counts; the other edge is ignored entirely.
  assign edge_pulse = primed & (rising_sel ? (sync2_reg & ~last_reg) : (~sync2_reg & last_reg));

endmodule

// ==== verilog/shadow_bank.sv ====
// Purpose: Shadow copy of the saved CPU context.
// Assumes: save is a one-clock pulse.
// Notes:   Held data come straight out of the storage register.
module shadow_bank #(
  parameter int WIDTH = 59
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             save,
  input  wire logic [WIDTH-1:0] save_data,
  output logic      [WIDTH-1:0] held_data
);

  logic [WIDTH-1:0] held_reg;
  logic [WIDTH-1:0] held_next;

  // Capture on save, otherwise keep the copy for the return.
  always_comb begin
    held_next = save ? save_data : held_reg;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  assign held_data = held_reg;

endmodule

// ==== verilog/cpu_interrupt_sequencer.sv ====
// Purpose: Interrupt flags, enables and CPU redirection sequence of an 8-bit core.
// Assumes: clock runs at quarter-phase rate; the CPU obeys the flush, push, vector and pop strobes.
// Notes:   Software access to the control, enable and flag registers is by plain write strobes.
`include "irq_seq_map.svh"

// Function
// - Any reset leaves redirection disabled until software sets the global enable.
// - Redirect needs global enable, source enable, and group enable for peripheral sources.
// - Flags set on their condition regardless of any enable bit.
// - Entry flushes prefetch, clears global enable, pushes PC, saves context, vectors to 0004h.
// - With global enable clear, flags still set; service follows when it is set again.
// - Return pops the stack, restores context and sets global enable together.
// - Flags stay until software clears them; a still-set enabled flag retriggers.
// - Latency is 3-4 cycles synchronous, 3-5 asynchronous, for any instruction length.
// - The pending condition is sampled once per instruction cycle in the first phase.
// - The external pin flag may be set anywhere from fourth to first phase.
// - Sources running without system clock, enabled before sleep, wake the device.
// - After wake, vector if global enable set, otherwise continue after sleep.
// - The instruction after sleep always executes before branching to the vector.
// - The external pin gives an asynchronous edge interrupt gated by its enable.
// - Edge select one means rising edges only; zero means falling edges only.
// - A selected pin edge sets its flag and redirects when both enables are set.
// - Save and restore W, status less TO/PD, bank, indirect and PC-high registers.
// - The edge select comes out of reset selecting rising edges.
module cpu_interrupt_sequencer #(
  parameter int N_PERIPH = 16
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Software writes.
  input  wire logic                ctrl_wr,
  input  wire logic [7:0]          ctrl_wdata,
  input  wire logic                en0_wr,
  input  wire logic [7:0]          en0_wdata,
  input  wire logic                flag0_wr,
  input  wire logic [7:0]          flag0_wdata,
  input  wire logic                pie_wr,
  input  wire logic [N_PERIPH-1:0] pie_wdata,
  input  wire logic                pir_wr,
  input  wire logic [N_PERIPH-1:0] pir_wdata,
  // Interrupt sources.
  input  wire logic                ext_pin,
  input  wire logic                tmr0_event,
  input  wire logic                ioc_event,
  input  wire logic [N_PERIPH-1:0] periph_event,
  input  wire logic [N_PERIPH-1:0] periph_async,
  // CPU pipeline.
  input  wire logic                instr_retire,
  input  wire logic                return_from_isr_op,
  input  wire logic                sleep_active,
  input  wire logic [14:0]         pc_in,
  input  wire logic [7:0]          w_in,
  input  wire logic [7:0]          status_in,
  input  wire logic [5:0]          bsr_in,
  input  wire logic [15:0]         fsr0_in,
  input  wire logic [15:0]         fsr1_in,
  input  wire logic [6:0]          pc_high_latch_in,
  // Register views.
  output logic [7:0]               irq_control_reg,
  output logic [7:0]               irq_enable_reg0,
  output logic [7:0]               irq_flag_reg0,
  output logic [N_PERIPH-1:0]      peripheral_enable_regs,
  output logic [N_PERIPH-1:0]      irq_flag_reg1,
  // CPU control.
  output irq_seq_pkg::phase_t      q_phase,
  output logic                     prefetch_flush,
  output logic                     stack_push,
  output logic [14:0]              push_pc,
  output logic                     stack_pop,
  output logic                     vector_load,
  output logic [14:0]              vector_addr,
  output logic                     context_restore,
  output logic [7:0]               restore_w,
  output logic [7:0]               restore_status,
  output logic [5:0]               restore_bsr,
  output logic [15:0]              restore_fsr0,
  output logic [15:0]              restore_fsr1,
  output logic [6:0]               restore_pc_high_latch,
  output logic                     wake_request,
  output logic                     in_entry
);

  localparam int CTX_W = 59;

  irq_seq_pkg::seq_state_t state_reg;
  irq_seq_pkg::seq_state_t state_next;
  irq_seq_pkg::phase_t     phase_reg;
  irq_seq_pkg::phase_t     phase_next;
  logic [7:0]              ctrl_reg;
  logic [7:0]              ctrl_next;
  logic [7:0]              en0_reg;
  logic [7:0]              en0_next;
  logic [7:0]              flag0_reg;
  logic [7:0]              flag0_next;
  logic [N_PERIPH-1:0]     pie_reg;
  logic [N_PERIPH-1:0]     pie_next;
  logic [N_PERIPH-1:0]     pir_reg;
  logic [N_PERIPH-1:0]     pir_next;
  logic [14:0]             push_pc_reg;
  logic [14:0]             push_pc_next;
  logic                    ext_edge;
  logic                    global_irq_enable;
  logic                    peripheral_irq_enable;
  logic                    core_pending;
  logic                    periph_pending;
  logic                    any_pending;
  logic                    wake_pending;
  logic                    phase_q1;
  logic                    phase_q4;
  logic                    take_irq;
  logic                    ctx_save;
  logic                    ret_take;
  logic [CTX_W-1:0]        ctx_in;
  logic [CTX_W-1:0]        ctx_held;

  // The pin edge detector synchronises first, so the flag lands cleanly.
  pin_edge_detect u_pin_edge (
    .clock      (clock),
    .arst_n     (arst_n),
    .pin_in     (ext_pin),
    .rising_sel (ctrl_reg[`CTRL_EDGE_BIT]),
    .edge_pulse (ext_edge)
  );

  // Status is saved without its time-out and power-down bits.
  assign ctx_in = {w_in, status_in[7:5], status_in[2:0], bsr_in, fsr0_in, fsr1_in, pc_high_latch_in};

  shadow_bank #(
    .WIDTH (CTX_W)
  ) u_shadow (
    .clock     (clock),
    .arst_n    (arst_n),
    .save      (ctx_save),
    .save_data (ctx_in),
    .held_data (ctx_held)
  );

  // Enable gating; every source funnels into one pending term with no priority.
  always_comb begin
    global_irq_enable            = ctrl_reg[`CTRL_GIE_BIT];
    peripheral_irq_enable           = ctrl_reg[`CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
    core_pending   = |(flag0_reg & en0_reg & 8'(`EN0_IMPL_MASK));
    periph_pending = peripheral_irq_enable & (|(pir_reg & pie_reg));
    any_pending    = core_pending | periph_pending;
    // Only sources that run without the system clock may wake: the pin and async peripherals.
    wake_pending   = (flag0_reg[`EN0_EXT_BIT] & en0_reg[`EN0_EXT_BIT])
                   | (|(pir_reg & pie_reg & periph_async));
    phase_q1       = (phase_reg == `PHASE_Q1);
    phase_q4       = (phase_reg == `PHASE_Q4);
  end

  // Quarter-phase counter; the instruction cycle is four clocks.
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= `PHASE_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Redirection decision and entry sequence strobes.
  always_comb begin
    take_irq     = (state_reg == irq_seq_pkg::ST_RUN) && phase_q1 && global_irq_enable && any_pending;
    ctx_save     = (state_reg == irq_seq_pkg::ST_SAVE) && phase_q1;
    ret_take     = (state_reg == irq_seq_pkg::ST_RUN) && return_from_isr_op && !take_irq;
    push_pc_next = take_irq ? pc_in : push_pc_reg;
  end

  // Sequencer: flush, save and vector each take one instruction cycle.
  // Fixed cycle counts keep latency identical for one- and two-cycle instructions.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irq_seq_pkg::ST_RUN: begin
        if (take_irq) begin
          state_next = irq_seq_pkg::ST_FLUSH;
        end else if (sleep_active) begin
          state_next = irq_seq_pkg::ST_SLEEP;
        end
      end
      irq_seq_pkg::ST_FLUSH: begin
        if (phase_q4) begin
          state_next = irq_seq_pkg::ST_SAVE;
        end
      end
      irq_seq_pkg::ST_SAVE: begin
        if (phase_q4) begin
          state_next = irq_seq_pkg::ST_VECTOR;
        end
      end
      irq_seq_pkg::ST_VECTOR: begin
        if (phase_q4) begin
          state_next = irq_seq_pkg::ST_RUN;
        end
      end
      irq_seq_pkg::ST_SLEEP: begin
        if (wake_pending) begin
          state_next = irq_seq_pkg::ST_WAKE;
        end
      end
      irq_seq_pkg::ST_WAKE: begin
        // The instruction after sleep retires before any branch is considered.
        if (instr_retire) begin
          state_next = irq_seq_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = irq_seq_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= irq_seq_pkg::ST_RUN;
      push_pc_reg <= 15'h0000;
    end else begin
      state_reg   <= state_next;
      push_pc_reg <= push_pc_next;
    end
  end

  // Control register: entry clears the global enable, return sets it, software writes the rest.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = ctrl_wdata & 8'(`CTRL_IMPL_MASK);
    end
    if (take_irq) begin
      ctrl_next[`CTRL_GIE_BIT] = 1'b0;
    end else if (ret_take) begin
      ctrl_next[`CTRL_GIE_BIT] = 1'b1;
    end
  end

  // Flags: the hardware set wins over a software clear in the same clock.
  // The pin flag may set in any phase, which covers the fourth-to-first phase window.
  always_comb begin
    en0_next   = en0_wr ? (en0_wdata & 8'(`EN0_IMPL_MASK)) : en0_reg;
    pie_next   = pie_wr ? pie_wdata : pie_reg;
    flag0_next = flag0_wr ? (flag0_wdata & 8'(`EN0_IMPL_MASK)) : flag0_reg;
    pir_next   = pir_wr ? pir_wdata : pir_reg;
    flag0_next[`EN0_EXT_BIT]  = flag0_next[`EN0_EXT_BIT] | ext_edge;
    flag0_next[`EN0_IOC_BIT]  = flag0_next[`EN0_IOC_BIT] | ioc_event;
    flag0_next[`EN0_TMR0_BIT] = flag0_next[`EN0_TMR0_BIT] | tmr0_event;
    pir_next   = pir_next | periph_event;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= `CTRL_RESET_VAL;
      en0_reg   <= `EN0_RESET_VAL;
      flag0_reg <= `FLAG0_RESET_VAL;
      pie_reg   <= '0;
      pir_reg   <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      en0_reg   <= en0_next;
      flag0_reg <= flag0_next;
      pie_reg   <= pie_next;
      pir_reg   <= pir_next;
    end
  end

  // Register views for software polling.
  assign irq_control_reg        = ctrl_reg;
  assign irq_enable_reg0        = en0_reg;
  assign irq_flag_reg0          = flag0_reg;
  assign peripheral_enable_regs = pie_reg;
  assign irq_flag_reg1          = pir_reg;

  // CPU strobes; flush on the decision, push and save one cycle later, vector last.
  assign q_phase        = phase_reg;
  assign prefetch_flush = take_irq;
  assign stack_push     = ctx_save;
  assign push_pc        = push_pc_reg;
  assign vector_load    = (state_reg == irq_seq_pkg::ST_VECTOR) && phase_q1;
  assign vector_addr    = `IRQ_VECTOR_ADDR;
  assign stack_pop      = ret_take;
  assign context_restore = ret_take;
  assign wake_request   = (state_reg == irq_seq_pkg::ST_SLEEP) && wake_pending;
  assign in_entry       = (state_reg == irq_seq_pkg::ST_FLUSH) || (state_reg == irq_seq_pkg::ST_SAVE)
                        || (state_reg == irq_seq_pkg::ST_VECTOR);

  // Restored context; the CPU keeps its own time-out and power-down bits.
  assign restore_w      = ctx_held[58:51];
  assign restore_status = {ctx_held[50:48], status_in[`STATUS_TO_BIT], status_in[`STATUS_PD_BIT],
                           ctx_held[47:45]};
  assign restore_bsr    = ctx_held[44:39];
  assign restore_fsr0   = ctx_held[38:23];
  assign restore_fsr1   = ctx_held[22:7];
  assign restore_pc_high_latch = ctx_held[6:0];

endmodule

// ==== verif/irq_seq_monitor.sv ====
// Purpose: Concurrent checks on the interrupt sequencer ports.
// Assumes: Bound to every sequencer instance; one clock domain.
// Notes:   Entry spacing follows the hand-over timing of flush, push and vector strobes.
module irq_seq_monitor #(
  parameter int N_PERIPH = 16
) (
  input wire logic                clock,
  input wire logic                arst_n,
  input wire logic                tmr0_event,
  input wire logic                ext_pin,
  input wire logic                return_from_isr_op,
  input wire logic [7:0]          irq_control_reg,
  input wire logic [7:0]          irq_enable_reg0,
  input wire logic [7:0]          irq_flag_reg0,
  input wire logic [N_PERIPH-1:0] peripheral_enable_regs,
  input wire logic [N_PERIPH-1:0] irq_flag_reg1,
  input irq_seq_pkg::phase_t      q_phase,
  input wire logic                prefetch_flush,
  input wire logic                stack_push,
  input wire logic                stack_pop,
  input wire logic                vector_load,
  input wire logic [14:0]         vector_addr,
  input wire logic                context_restore
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Reset values are checked while reset is held, so this one is never disabled.
  chk_reset_state: assert property (disable iff (1'b0) !arst_n ##1 !arst_n
    |-> irq_control_reg == 8'h01 && !prefetch_flush)
    else $error("reset state wrong");
  // A redirect decision only happens in the first phase with the global enable set.
  chk_flush_phase: assert property (prefetch_flush |-> q_phase == 2'h0 && irq_control_reg[7])
    else $error("flush outside first phase or with global enable clear");
  chk_pending_src: assert property (prefetch_flush |-> (|(irq_flag_reg0 & irq_enable_reg0 & 8'h31))
    || (irq_control_reg[6] && |(irq_flag_reg1 & peripheral_enable_regs)))
    else $error("flush without an enabled pending source");
  chk_gie_cleared: assert property (prefetch_flush |=> !irq_control_reg[7] [*8])
    else $error("global enable not cleared during entry");
  chk_entry_order: assert property (prefetch_flush |-> ##4 stack_push ##4 vector_load)
    else $error("entry strobes out of order");
  chk_vector_addr: assert property (vector_load |-> vector_addr == 15'h0004 && !irq_control_reg[7])
    else $error("vector address wrong");
  chk_return_gie: assert property (context_restore |->
    return_from_isr_op && stack_pop ##1 irq_control_reg[7])
    else $error("return did not pop and set global enable");
  chk_flag_tmr0: assert property (tmr0_event |=> irq_flag_reg0[5])
    else $error("timer flag not set");
  chk_ext_edge: assert property (($rose(ext_pin) && irq_control_reg[0])
    || ($fell(ext_pin) && !irq_control_reg[0]) |-> ##[1:4] irq_flag_reg0[0])
    else $error("pin edge did not set flag");
endmodule

bind cpu_interrupt_sequencer irq_seq_monitor #(.N_PERIPH(N_PERIPH)) mon (.clock, .arst_n, .tmr0_event, .ext_pin,
  .return_from_isr_op, .irq_control_reg, .irq_enable_reg0, .irq_flag_reg0, .peripheral_enable_regs, .irq_flag_reg1,
  .q_phase, .prefetch_flush, .stack_push, .stack_pop, .vector_load, .vector_addr, .context_restore);

// ==== verif/cpu_model.sv ====
// Purpose: Behavioural CPU pipeline facing the sequencer.
// Assumes: One instruction per four clocks; strobes are one clock wide.
// Notes:   Live context is derived from the PC, so saved and live values differ.
module cpu_model (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 sleep_active,
  input  wire logic                 prefetch_flush,
  input  wire logic                 stack_push,
  input  wire logic                 stack_pop,
  input  wire logic                 vector_load,
  input  wire logic                 in_entry,
  input  irq_seq_pkg::phase_t       q_phase,
  input  wire logic [14:0]          push_pc,
  input  wire logic [14:0]          vector_addr,
  output logic                      instr_retire,
  output logic [14:0]               pc_in,
  output logic [7:0]                w_in,
  output logic [7:0]                status_in,
  output logic [5:0]                bsr_in,
  output logic [15:0]               fsr0_in,
  output logic [15:0]               fsr1_in,
  output logic [6:0]                pc_high_latch_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] pc, exp_ret;
  logic [14:0] stk[$];
  logic [7:0]  sv_w, sv_st;
  logic [5:0]  sv_b;
  logic [15:0] sv_f0, sv_f1;
  logic [6:0]  sv_pl;
  int          rc;

  // Context follows the PC so a stale restore cannot match by accident.
  assign pc_in     = pc;
  assign w_in      = pc[7:0] ^ 8'h5A;
  assign status_in = ~pc[7:0];
  assign bsr_in    = pc[5:0];
  assign fsr0_in   = {pc, 1'b1};
  assign fsr1_in   = {1'b0, pc};
  assign pc_high_latch_in = pc[14:8];

  // Pipeline: the stack holds pushed PCs; the PC halts while asleep or in entry.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc <= 15'h0010;
      instr_retire <= 1'b0;
      rc <= 0;
    end else begin
      instr_retire <= 1'b0;
      if (prefetch_flush) exp_ret <= pc;
      if (stack_push) begin
        stk.push_back(push_pc);
        sv_w <= w_in;
        sv_f0 <= fsr0_in;
        sv_f1 <= fsr1_in;
        sv_st <= status_in;
        sv_b <= bsr_in;
        sv_pl <= pc_high_latch_in;
      end
      if (vector_load) pc <= vector_addr;
      else if (stack_pop && stk.size() > 0) pc <= stk.pop_back();
      else if (q_phase == 2'h3 && !sleep_active && !in_entry) begin
        pc <= pc + 15'h0001;
        instr_retire <= 1'b1;
        rc <= rc + 1;
      end
    end
  end
endmodule

// ==== verif/cpu_interrupt_sequencer_tb.sv ====
// Purpose: Self-checking bench for the interrupt sequencer.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes:   Asynchronous peripheral sources are tied inactive; the pin covers wake.
module cpu_interrupt_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, ctrl_wr, en0_wr, flag0_wr, pie_wr, pir_wr, ext_pin, tmr0_event, ioc_event;
  logic instr_retire, return_from_isr_op, sleep_active, prefetch_flush, stack_push, stack_pop, vector_load;
  logic context_restore, wake_request, in_entry;
  logic [7:0] ctrl_wdata, en0_wdata, flag0_wdata, w_in, status_in, restore_w, restore_status;
  logic [7:0] irq_control_reg, irq_enable_reg0, irq_flag_reg0;
  logic [15:0] pie_wdata, pir_wdata, periph_event, periph_async, peripheral_enable_regs, irq_flag_reg1;
  logic [15:0] fsr0_in, fsr1_in, restore_fsr0, restore_fsr1;
  logic [14:0] pc_in, push_pc, vector_addr;
  logic [5:0]  bsr_in, restore_bsr;
  logic [6:0]  pc_high_latch_in, restore_pc_high_latch;
  irq_seq_pkg::phase_t q_phase;
  int error_cnt = 0, samples_checked = 0, r0;

  cpu_interrupt_sequencer dut (.clock, .arst_n, .ctrl_wr, .ctrl_wdata, .en0_wr, .en0_wdata, .flag0_wr, .flag0_wdata,
    .pie_wr, .pie_wdata, .pir_wr, .pir_wdata, .ext_pin, .tmr0_event, .ioc_event, .periph_event, .periph_async,
    .instr_retire, .return_from_isr_op, .sleep_active, .pc_in, .w_in, .status_in, .bsr_in, .fsr0_in, .fsr1_in,
    .pc_high_latch_in, .irq_control_reg, .irq_enable_reg0, .irq_flag_reg0, .peripheral_enable_regs, .irq_flag_reg1,
    .q_phase, .prefetch_flush, .stack_push, .push_pc, .stack_pop, .vector_load, .vector_addr, .context_restore,
    .restore_w, .restore_status, .restore_bsr, .restore_fsr0, .restore_fsr1, .restore_pc_high_latch, .wake_request,
    .in_entry);
  cpu_model m (.clock, .arst_n, .sleep_active, .prefetch_flush, .stack_push, .stack_pop, .vector_load, .in_entry,
    .q_phase, .push_pc, .vector_addr, .instr_retire, .pc_in, .w_in, .status_in, .bsr_in, .fsr0_in, .fsr1_in,
    .pc_high_latch_in);

  // Free-running 20 MHz clock.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task tick; @(posedge clock); #2; endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Software write strobes are held for exactly one clock; a quiet clock follows so no strobe toggles twice at once.
  task wr(input int k, input logic [15:0] d);
    case (k)
      0: begin ctrl_wr = 1'b1; ctrl_wdata = d[7:0]; end
      1: begin en0_wr = 1'b1; en0_wdata = d[7:0]; end
      2: begin flag0_wr = 1'b1; flag0_wdata = d[7:0]; end
      3: begin pie_wr = 1'b1; pie_wdata = d; end
      default: begin pir_wr = 1'b1; pir_wdata = d; end
    endcase
    tick;
    {ctrl_wr, en0_wr, flag0_wr, pie_wr, pir_wr} = 5'h00;
    tick;
  endtask
  // Bounded wait; the caller decides whether running out is a failure.
  task wt(input int k, input int lim, output int n);
    n = 0;
    while (n < lim && (k == 0 ? prefetch_flush : k == 1 ? vector_load : wake_request) !== 1'b1) begin
      tick;
      n++;
    end
  endtask
  task need(input int k, input int lim);
    int n;
    wt(k, lim, n);
    if (n == lim) begin
      error_cnt++;
      $display("FAIL strobe %0d exp 1 seen 0", k);
      stop_test;
    end
  endtask
  task quiet;
    int n;
    wt(0, 12, n);
    chk("no entry", n, 12);
  endtask
  task isr_rest;
    tick;
    chk("gie in entry", irq_control_reg[7], 1'b0);
    need(1, 12);
    tick;
    chk("vector pc", m.pc, 15'h0004);
    repeat (3) tick;
  endtask
  task isr; need(0, 40); isr_rest; endtask
  // The return pops, restores and re-enables in one clock.
  task ret;
    return_from_isr_op = 1'b1;
    #1;
    chk("pop", stack_pop & context_restore, 1'b1);
    chk("w", restore_w, m.sv_w);
    chk("fsr0", restore_fsr0, m.sv_f0);
    chk("pc_high_latch", restore_pc_high_latch, m.sv_pl);
    chk("fsr1", restore_fsr1, m.sv_f1);
    chk("bsr", restore_bsr, m.sv_b);
    chk("status kept", {restore_status[7:5], restore_status[2:0]}, {m.sv_st[7:5], m.sv_st[2:0]});
    chk("status", restore_status[4:3], status_in[4:3]);
    tick;
    return_from_isr_op = 1'b0;
    chk("ret pc", m.pc, m.exp_ret);
    chk("gie after ret", irq_control_reg[7], 1'b1);
  endtask

  // Main sequence.
  initial begin
    {arst_n, ctrl_wr, en0_wr, flag0_wr, pie_wr, pir_wr, ext_pin, tmr0_event, ioc_event} = 9'h000;
    {return_from_isr_op, sleep_active, ctrl_wdata, en0_wdata, flag0_wdata} = 26'h000_0000;
    {pie_wdata, pir_wdata, periph_event, periph_async} = 64'h0000_0000_0000_0000;
    repeat (8) @(posedge clock);
    #2 arst_n = 1'b1;
    chk("ctrl reset", irq_control_reg, 8'h01);
    chk("en0 reset", irq_enable_reg0, 8'h00);
    wr(0, 16'h00FF);
    chk("ctrl bits", irq_control_reg, 8'hC1);
    wr(0, 16'h0001);
    $display("test reset done");
    {tmr0_event, ioc_event, periph_event} = 18'h3_0008;
    tick;
    {tmr0_event, ioc_event, periph_event} = 18'h0_0000;
    tick;
    chk("flag0", irq_flag_reg0, 8'h30);
    chk("flag1", irq_flag_reg1, 16'h0008);
    wr(1, 16'h0020);
    quiet;
    wr(0, 16'h0081);
    isr;
    ret;
    isr;
    wr(2, 16'h0000);
    ret;
    quiet;
    $display("test core source done");
    wr(3, 16'h0008);
    chk("pie", peripheral_enable_regs, 16'h0008);
    quiet;
    wr(0, 16'h00C1);
    isr;
    wr(4, 16'h0000);
    ret;
    quiet;
    wr(0, 16'h0001);
    wr(1, 16'h0000);
    $display("test peripheral source done");
    for (int s = 1; s >= 0; s--) begin
      wr(0, 16'(s));
      ext_pin = s[0];
      repeat (6) tick;
      wr(2, 16'h0000);
      ext_pin = !s[0];
      repeat (6) tick;
      chk("wrong edge", irq_flag_reg0[0], 1'b0);
      ext_pin = s[0];
      repeat (6) tick;
      chk("right edge", irq_flag_reg0[0], 1'b1);
    end
    $display("test pin edges done");
    wr(2, 16'h0000);
    wr(1, 16'h0001);
    wr(0, 16'h0081);
    sleep_active = 1'b1;
    repeat (4) tick;
    ext_pin = 1'b1;
    need(2, 20);
    r0 = m.rc;
    sleep_active = 1'b0;
    need(0, 40);
    chk("retired first", m.rc > r0, 1'b1);
    isr_rest;
    wr(2, 16'h0000);
    ret;
    $display("test sleep wake done");
    // Mid-run reset with the pin held high: no false rising edge may be flagged afterwards.
    arst_n = 1'b0;
    repeat (2) tick;
    arst_n = 1'b1;
    chk("ctrl mid reset", irq_control_reg, 8'h01);
    repeat (6) tick;
    chk("no false pin edge", irq_flag_reg0, 8'h00);
    quiet;
    $display("test mid reset done");
    stop_test;
  end
endmodule
